// ===== hdl/itc_pkg.sv
// Constants, field layouts and state codes of the interrupt and trap controller.
// Assumes one 100 MHz clock, an asynchronous active-high reset and a classic
// Wishbone master with 32-bit data.
// Behaviour
// - A request reaches the CPU vector port within about eight clocks.
// - Each node is set by software to vector or to a transfer channel.
// - A channel service steals one bus cycle, with no vector branch.
// - A service moves a byte or word, then steps source and/or destination.
// - Each channel counts services down, except in continuous mode.
// - At a zero count the node raises its own standard vector.
// - Eight independent transfer channels exist.
// - Each node has request, enable and a sixteen-level priority field.
// - An accepted service is pre-empted only by strictly higher priority.
// - Each node has its own vector location.
// - Fast external inputs detect rising, falling or both edges.
// - Trap numbers 00h-7Fh vector in steps of 4h shifted left by the spacing field, keeping CPU priority.
// - Software setting a request bit acts like a hardware request.
// - Vectors lie in the segment register, spaced by the spacing field.
// - Hardware traps branch at once, unmaskable, setting their flag.
// - Hardware traps pre-empt only lower trap classes; traps block normal services.
// - Hardware, software and watchdog reset vector to 0000h, trap 00h.
// - Class A traps: NMI 0008h, stack over, stack under, break 0020h.
// - Class B traps share 0028h with one flag per cause.
// - A falling edge on the NMI pin starts the NMI trap.
package itc_pkg;
	localparam int NODE_COUNT = 16;
	localparam int CHAN_COUNT = 8;
	localparam int EXT_COUNT = 8;
	localparam int TRAP_FLAG_COUNT = 8;
	localparam int CLOCK_MHZ = 100;
	localparam int RESPONSE_CYCLES = 8;

	localparam logic [7:0] TRAP_FLAG_OFS = 8'h40;
	localparam logic [7:0] VEC_SEG_OFS = 8'h44;
	localparam logic [7:0] CPU_CFG_OFS = 8'h48;
	localparam logic [7:0] EDGE_SEL_OFS = 8'h4C;
	localparam logic [7:0] CHAN_BASE = 8'h80;
	localparam logic [3:0] CH_SRC_OFS = 4'h0;
	localparam logic [3:0] CH_DST_OFS = 4'h4;
	localparam logic [3:0] CH_CTL_OFS = 4'h8;

	localparam int PRIO_LSB = 2;
	localparam int EN_BIT = 6;
	localparam int REQ_BIT = 7;
	localparam int USE_CH_BIT = 8;
	localparam int CH_LSB = 9;
	localparam int WORD_BIT = 8;
	localparam int INC_SRC_BIT = 9;
	localparam int INC_DST_BIT = 10;
	localparam int CONT_BIT = 11;

	localparam int FLAG_ILLOPND = 0;
	localparam int FLAG_PROT = 1;
	localparam int FLAG_PMERR = 2;
	localparam int FLAG_UNDEF = 3;
	localparam int FLAG_BRK = 4;
	localparam int FLAG_STACK_UNDERFLOW_FLAG = 5;
	localparam int FLAG_STACK_OVERFLOW_FLAG = 6;
	localparam int FLAG_NMI = 7;

	localparam logic [6:0] TRAPNUM_RESET = 7'h00;
	localparam logic [6:0] TRAPNUM_NMI = 7'h02;
	localparam logic [6:0] TRAPNUM_STACK_OVERFLOW_FLAG = 7'h04;
	localparam logic [6:0] TRAPNUM_STACK_UNDERFLOW_FLAG = 7'h06;
	localparam logic [6:0] TRAPNUM_BRK = 7'h08;
	localparam logic [6:0] TRAPNUM_CLASS_B = 7'h0A;
	localparam logic [6:0] NODE_TRAP_BASE = 7'h40;

	localparam logic [1:0] CLASS_NONE = 2'b00;
	localparam logic [1:0] CLASS_B = 2'b01;
	localparam logic [1:0] CLASS_A = 2'b10;
	localparam logic [1:0] CLASS_RESET = 2'b11;

	localparam logic [1:0] EDGE_OFF = 2'b00;
	localparam logic [1:0] EDGE_RISE = 2'b01;
	localparam logic [1:0] EDGE_FALL = 2'b10;
	localparam logic [1:0] EDGE_BOTH = 2'b11;

	localparam logic [7:0] VEC_SEG_RESET = 8'h00;
	localparam logic [1:0] SPACING_RESET = 2'b00;
	localparam logic [15:0] EDGE_SEL_RESET = 16'h0000;
	localparam logic [3:0] SEL_RESET = 4'h0;

	localparam logic [3:0] TSEL_RESET_EVT = 4'h8;
	localparam logic [3:0] TSEL_SOFT = 4'h9;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_VEC = 2'b01,
		ST_XFER = 2'b10
	} serve_state_t;
endpackage : itc_pkg

// ===== hdl/edge_event.sv
// Edge detector for one fast external interrupt input.
// Assumes the pin is already synchronous to i_clk.
`timescale 1ns/10ps
`default_nettype none
module edge_event
	import itc_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_pin,
	input wire logic [1:0] i_mode,
	output logic o_event
);
	logic last_reg;
	wire rise = i_pin & ~last_reg;
	wire fall = ~i_pin & last_reg;
	wire hit = (i_mode[0] & rise) | (i_mode[1] & fall);

	// Idle level high so a pin pulled up at reset gives no false falling edge
	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			last_reg <= 1'b1;
			o_event <= 1'b0;
		end
		else
		begin
			last_reg <= i_pin;
			o_event <= hit;
		end
	end
endmodule : edge_event
`default_nettype wire

// ===== hdl/interrupt_and_trap_controller.sv
// Prioritised interrupt, transfer channel and trap controller.
// Assumes a classic Wishbone master, CPU handshakes that hold each request
// until acknowledged, and event inputs synchronous to i_clk.
`timescale 1ns/10ps
`default_nettype none
module interrupt_and_trap_controller
	import itc_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	input wire logic [itc_pkg::EXT_COUNT-1:0] i_fast_ext_irq_input,
	input wire logic [itc_pkg::NODE_COUNT-itc_pkg::EXT_COUNT-1:0] i_periph_req,
	input wire logic i_nmi_pin,
	input wire logic i_stack_overflow,
	input wire logic i_stack_underflow,
	input wire logic i_soft_break,
	input wire logic i_undef_opcode,
	input wire logic i_pmem_access_error,
	input wire logic i_protected_fault,
	input wire logic i_illegal_operand,
	input wire logic i_reset_event,
	input wire logic i_trap_instr,
	input wire logic [6:0] i_trap_instr_num,
	input wire logic [3:0] i_cpu_level,
	input wire logic [1:0] i_cpu_trap_class,
	output logic o_vec_req,
	output logic [23:0] o_vec_addr,
	output logic [6:0] o_vec_trap_num,
	output logic [3:0] o_vec_level,
	output logic o_vec_is_trap,
	input wire logic i_vec_ack,
	output logic o_xfer_req,
	output logic [15:0] o_xfer_src,
	output logic [15:0] o_xfer_dst,
	output logic o_xfer_word,
	input wire logic i_xfer_ack,
	output logic [7:0] o_trap_flags
);
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		merge16 = {sel[1] ? nw[15:8] : old[15:8], sel[0] ? nw[7:0] : old[7:0]};
	endfunction : merge16

	// Spacing field scales the 4-byte base step by powers of two
	function automatic logic [15:0] vec_offset(input logic [6:0] num, input logic [1:0] sp);
		vec_offset = {7'h00, num, 2'b00} << sp;
	endfunction : vec_offset

	serve_state_t state_reg;
	logic [3:0] node_prio_reg [NODE_COUNT];
	logic [2:0] node_ch_reg [NODE_COUNT];
	logic [NODE_COUNT-1:0] node_en_reg, node_req_reg, node_usech_reg;
	logic [15:0] chan_src_reg [CHAN_COUNT];
	logic [15:0] chan_dst_reg [CHAN_COUNT];
	logic [7:0] chan_cnt_reg [CHAN_COUNT];
	logic [CHAN_COUNT-1:0] chan_word_reg, chan_incs_reg, chan_incd_reg, chan_cont_reg;
	logic [7:0] trap_flag_register, trap_pend_reg;
	logic reset_pend_reg, soft_pend_reg;
	logic [6:0] soft_num_reg;
	logic [7:0] vector_segment_reg;
	logic [1:0] vector_spacing_field;
	logic [15:0] edge_sel_reg;
	logic [3:0] cur_node_reg, cur_tsel_reg;
	logic [EXT_COUNT-1:0] ext_event;
	logic nmi_event;

	// Bus slave: ack one cycle after the strobe, one cycle long
	wire bus_req = i_wb_cyc & i_wb_stb;
	wire wr_fire = bus_req & i_wb_we & o_wb_ack;
	wire [7:0] adr = {i_wb_adr[7:2], 2'b00};
	wire node_hit = adr < TRAP_FLAG_OFS;
	wire [3:0] node_sel = adr[5:2];
	wire chan_hit = adr >= CHAN_BASE;
	wire [2:0] chan_sel = adr[6:4];
	wire [3:0] chan_fld = adr[3:0];
	wire [15:0] wr16 = i_wb_dat[15:0];

	genvar g;
	generate
		for (g = 0; g < EXT_COUNT; g++)
		begin : g_ext
			edge_event u_edge (
				.i_clk(i_clk),
				.i_reset(i_reset),
				.i_pin(i_fast_ext_irq_input[g]),
				.i_mode(edge_sel_reg[2*g+1:2*g]),
				.o_event(ext_event[g])
			);
		end
	endgenerate

	edge_event u_nmi_edge (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_pin(i_nmi_pin),
		.i_mode(EDGE_FALL),
		.o_event(nmi_event)
	);

	// Arbitration over pending enabled nodes above the CPU level
	logic best_found;
	logic [3:0] best_idx;
	logic [3:0] best_prio;
	always_comb
	begin
		best_found = 1'b0;
		best_idx = 4'h0;
		best_prio = i_cpu_level;
		for (int i = 0; i < NODE_COUNT; i++)
		begin
			if (node_req_reg[i] && node_en_reg[i] && node_prio_reg[i] > best_prio)
			begin
				best_found = 1'b1;
				best_idx = 4'(i);
				best_prio = node_prio_reg[i];
			end
		end
	end

	wire std_ok = best_found && (i_cpu_trap_class == CLASS_NONE);
	wire [2:0] win_ch = node_ch_reg[best_idx];
	wire win_xfer = node_usech_reg[best_idx] &&
		(chan_cnt_reg[win_ch] != 8'h00 || chan_cont_reg[win_ch]);

	// Trap selection: reset, then class A in order, then class B, then software traps
	logic trap_go;
	logic [3:0] trap_sel;
	logic [6:0] trap_num;
	always_comb
	begin
		trap_go = 1'b1;
		trap_sel = TSEL_RESET_EVT;
		trap_num = TRAPNUM_RESET;
		if (reset_pend_reg && i_cpu_trap_class != CLASS_RESET)
		begin
			trap_sel = TSEL_RESET_EVT;
		end
		else if (trap_pend_reg[FLAG_NMI] && i_cpu_trap_class < CLASS_A)
		begin
			trap_sel = 4'(FLAG_NMI);
			trap_num = TRAPNUM_NMI;
		end
		else if (trap_pend_reg[FLAG_STACK_OVERFLOW_FLAG] && i_cpu_trap_class < CLASS_A)
		begin
			trap_sel = 4'(FLAG_STACK_OVERFLOW_FLAG);
			trap_num = TRAPNUM_STACK_OVERFLOW_FLAG;
		end
		else if (trap_pend_reg[FLAG_STACK_UNDERFLOW_FLAG] && i_cpu_trap_class < CLASS_A)
		begin
			trap_sel = 4'(FLAG_STACK_UNDERFLOW_FLAG);
			trap_num = TRAPNUM_STACK_UNDERFLOW_FLAG;
		end
		else if (trap_pend_reg[FLAG_BRK] && i_cpu_trap_class < CLASS_A)
		begin
			trap_sel = 4'(FLAG_BRK);
			trap_num = TRAPNUM_BRK;
		end
		else if (trap_pend_reg[FLAG_UNDEF:FLAG_ILLOPND] != 4'h0 && i_cpu_trap_class < CLASS_B)
		begin
			trap_sel = trap_pend_reg[FLAG_UNDEF] ? 4'(FLAG_UNDEF) :
				trap_pend_reg[FLAG_PMERR] ? 4'(FLAG_PMERR) :
				trap_pend_reg[FLAG_PROT] ? 4'(FLAG_PROT) : 4'(FLAG_ILLOPND);
			trap_num = TRAPNUM_CLASS_B;
		end
		else if (soft_pend_reg)
		begin
			trap_sel = TSEL_SOFT;
			trap_num = soft_num_reg;
		end
		else
		begin
			trap_go = 1'b0;
		end
	end

	wire vec_done = (state_reg == ST_VEC) && i_vec_ack;
	wire xfer_done = (state_reg == ST_XFER) && i_xfer_ack;
	wire [2:0] cur_ch = node_ch_reg[cur_node_reg];
	wire cnt_to_zero = ~chan_cont_reg[cur_ch] && chan_cnt_reg[cur_ch] == 8'h01;
	wire trap_load = trap_go && ((state_reg == ST_IDLE) || (state_reg == ST_VEC && !o_vec_is_trap &&
		!i_vec_ack));
	wire [15:0] step = chan_word_reg[cur_ch] ? 16'h0002 : 16'h0001;

	// Service sequencer and CPU-facing outputs
	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			state_reg <= ST_IDLE;
			cur_node_reg <= SEL_RESET;
			cur_tsel_reg <= SEL_RESET;
			o_vec_req <= 1'b0;
			o_vec_addr <= 24'h000000;
			o_vec_trap_num <= 7'h00;
			o_vec_level <= 4'h0;
			o_vec_is_trap <= 1'b0;
			o_xfer_req <= 1'b0;
			o_xfer_src <= 16'h0000;
			o_xfer_dst <= 16'h0000;
			o_xfer_word <= 1'b0;
		end
		else if (trap_load)
		begin
			state_reg <= ST_VEC;
			cur_tsel_reg <= trap_sel;
			o_vec_req <= 1'b1;
			o_vec_is_trap <= 1'b1;
			o_vec_trap_num <= trap_num;
			o_vec_addr <= {vector_segment_reg, vec_offset(trap_num, vector_spacing_field)};
			o_vec_level <= i_cpu_level;
		end
		else if (state_reg == ST_IDLE && std_ok && win_xfer)
		begin
			state_reg <= ST_XFER;
			cur_node_reg <= best_idx;
			o_xfer_req <= 1'b1;
			o_xfer_src <= chan_src_reg[win_ch];
			o_xfer_dst <= chan_dst_reg[win_ch];
			o_xfer_word <= chan_word_reg[win_ch];
		end
		else if (state_reg == ST_IDLE && std_ok)
		begin
			state_reg <= ST_VEC;
			cur_node_reg <= best_idx;
			o_vec_req <= 1'b1;
			o_vec_is_trap <= 1'b0;
			o_vec_trap_num <= NODE_TRAP_BASE + 7'(best_idx);
			o_vec_addr <= {vector_segment_reg,
				vec_offset(NODE_TRAP_BASE + 7'(best_idx), vector_spacing_field)};
			o_vec_level <= best_prio;
		end
		else if (vec_done || xfer_done)
		begin
			state_reg <= ST_IDLE;
			o_vec_req <= 1'b0;
			o_xfer_req <= 1'b0;
		end
	end

	// Node requests: hardware set wins over any clear in the same cycle
	generate
		for (g = 0; g < NODE_COUNT; g++)
		begin : g_node
			wire hw_set = (g < EXT_COUNT) ? ext_event[g % EXT_COUNT] :
				i_periph_req[(g + EXT_COUNT) % NODE_COUNT % (NODE_COUNT - EXT_COUNT)];
			wire wr_this = wr_fire && node_hit && node_sel == 4'(g);
			wire served = ((vec_done && !o_vec_is_trap) || (xfer_done && !cnt_to_zero)) &&
				cur_node_reg == 4'(g);
			logic req_next;
			always_comb
			begin
				req_next = node_req_reg[g];
				if (wr_this && i_wb_sel[0])
					req_next = wr16[REQ_BIT];
				else if (served)
					req_next = 1'b0;
				if (hw_set)
					req_next = 1'b1;
			end
			always_ff @(posedge i_clk or posedge i_reset)
			begin
				if (i_reset)
				begin
					node_req_reg[g] <= 1'b0;
					node_en_reg[g] <= 1'b0;
					node_prio_reg[g] <= 4'h0;
					node_usech_reg[g] <= 1'b0;
					node_ch_reg[g] <= 3'h0;
				end
				else
				begin
					node_req_reg[g] <= req_next;
					if (wr_this && i_wb_sel[0])
					begin
						node_en_reg[g] <= wr16[EN_BIT];
						node_prio_reg[g] <= wr16[PRIO_LSB+3:PRIO_LSB];
					end
					if (wr_this && i_wb_sel[1])
					begin
						node_usech_reg[g] <= wr16[USE_CH_BIT];
						node_ch_reg[g] <= wr16[CH_LSB+2:CH_LSB];
					end
				end
			end
		end
	endgenerate

	// Transfer channels: enabled pointers step, and the counter unless continuous, after each stolen cycle
	generate
		for (g = 0; g < CHAN_COUNT; g++)
		begin : g_chan
			wire wr_ch = wr_fire && chan_hit && chan_sel == 3'(g);
			wire done_here = xfer_done && cur_ch == 3'(g);
			always_ff @(posedge i_clk or posedge i_reset)
			begin
				if (i_reset)
				begin
					chan_src_reg[g] <= 16'h0000;
					chan_dst_reg[g] <= 16'h0000;
					chan_cnt_reg[g] <= 8'h00;
					chan_word_reg[g] <= 1'b0;
					chan_incs_reg[g] <= 1'b0;
					chan_incd_reg[g] <= 1'b0;
					chan_cont_reg[g] <= 1'b0;
				end
				else if (done_here)
				begin
					if (chan_incs_reg[g])
						chan_src_reg[g] <= chan_src_reg[g] + step;
					if (chan_incd_reg[g])
						chan_dst_reg[g] <= chan_dst_reg[g] + step;
					if (!chan_cont_reg[g])
						chan_cnt_reg[g] <= chan_cnt_reg[g] - 8'h01;
				end
				else if (wr_ch && chan_fld == CH_SRC_OFS)
					chan_src_reg[g] <= merge16(chan_src_reg[g], i_wb_dat, i_wb_sel);
				else if (wr_ch && chan_fld == CH_DST_OFS)
					chan_dst_reg[g] <= merge16(chan_dst_reg[g], i_wb_dat, i_wb_sel);
				else if (wr_ch && chan_fld == CH_CTL_OFS)
				begin
					if (i_wb_sel[0])
						chan_cnt_reg[g] <= wr16[7:0];
					if (i_wb_sel[1])
					begin
						chan_word_reg[g] <= wr16[WORD_BIT];
						chan_incs_reg[g] <= wr16[INC_SRC_BIT];
						chan_incd_reg[g] <= wr16[INC_DST_BIT];
						chan_cont_reg[g] <= wr16[CONT_BIT];
					end
				end
			end
		end
	endgenerate

	// Trap flags: sticky until written with one; a new event wins over the clear
	wire [7:0] trap_in = {nmi_event, i_stack_overflow, i_stack_underflow, i_soft_break,
		i_undef_opcode, i_pmem_access_error, i_protected_fault, i_illegal_operand};
	wire flag_wr = wr_fire && adr == TRAP_FLAG_OFS && i_wb_sel[0];
	wire [7:0] flag_clr = flag_wr ? wr16[7:0] : 8'h00;
	wire trap_served = vec_done && o_vec_is_trap;
	wire [7:0] pend_clr = (trap_served && cur_tsel_reg < 4'(TRAP_FLAG_COUNT)) ?
		8'h01 << cur_tsel_reg[2:0] : 8'h00;

	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			trap_flag_register <= 8'h00;
			trap_pend_reg <= 8'h00;
			reset_pend_reg <= 1'b1;
			soft_pend_reg <= 1'b0;
			soft_num_reg <= 7'h00;
			o_trap_flags <= 8'h00;
		end
		else
		begin
			trap_flag_register <= (trap_flag_register & ~flag_clr) | trap_in;
			o_trap_flags <= (trap_flag_register & ~flag_clr) | trap_in;
			trap_pend_reg <= (trap_pend_reg & ~pend_clr) | trap_in;
			reset_pend_reg <= i_reset_event |
				(reset_pend_reg & ~(trap_served && cur_tsel_reg == TSEL_RESET_EVT));
			if (i_trap_instr && !soft_pend_reg)
			begin
				soft_pend_reg <= 1'b1;
				soft_num_reg <= i_trap_instr_num;
			end
			else if (trap_served && cur_tsel_reg == TSEL_SOFT)
				soft_pend_reg <= 1'b0;
		end
	end

	// Configuration registers
	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			vector_segment_reg <= VEC_SEG_RESET;
			vector_spacing_field <= SPACING_RESET;
			edge_sel_reg <= EDGE_SEL_RESET;
		end
		else if (wr_fire && adr == VEC_SEG_OFS && i_wb_sel[0])
			vector_segment_reg <= wr16[7:0];
		else if (wr_fire && adr == CPU_CFG_OFS && i_wb_sel[0])
			vector_spacing_field <= wr16[1:0];
		else if (wr_fire && adr == EDGE_SEL_OFS)
			edge_sel_reg <= merge16(edge_sel_reg, i_wb_dat, i_wb_sel);
	end

	// Read mux; unmapped addresses read as zero
	logic [15:0] rd_data;
	always_comb
	begin
		rd_data = 16'h0000;
		if (node_hit)
		begin
			rd_data[PRIO_LSB+3:PRIO_LSB] = node_prio_reg[node_sel];
			rd_data[EN_BIT] = node_en_reg[node_sel];
			rd_data[REQ_BIT] = node_req_reg[node_sel];
			rd_data[USE_CH_BIT] = node_usech_reg[node_sel];
			rd_data[CH_LSB+2:CH_LSB] = node_ch_reg[node_sel];
		end
		else if (chan_hit && chan_fld == CH_SRC_OFS)
			rd_data = chan_src_reg[chan_sel];
		else if (chan_hit && chan_fld == CH_DST_OFS)
			rd_data = chan_dst_reg[chan_sel];
		else if (chan_hit && chan_fld == CH_CTL_OFS)
			rd_data = {4'h0, chan_cont_reg[chan_sel], chan_incd_reg[chan_sel],
				chan_incs_reg[chan_sel], chan_word_reg[chan_sel], chan_cnt_reg[chan_sel]};
		else if (adr == TRAP_FLAG_OFS)
			rd_data = {8'h00, trap_flag_register};
		else if (adr == VEC_SEG_OFS)
			rd_data = {8'h00, vector_segment_reg};
		else if (adr == CPU_CFG_OFS)
			rd_data = {14'h0000, vector_spacing_field};
		else if (adr == EDGE_SEL_OFS)
			rd_data = edge_sel_reg;
	end

	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			o_wb_ack <= 1'b0;
			o_wb_dat <= 32'h00000000;
		end
		else
		begin
			o_wb_ack <= bus_req & ~o_wb_ack;
			if (bus_req && !o_wb_ack)
				o_wb_dat <= {16'h0000, rd_data};
		end
	end
endmodule : interrupt_and_trap_controller
`default_nettype wire

// ===== testbench/itc_monitor.sv
// Port assertions for the interrupt and trap controller.
// Assumes a bind to the top module, one clock and an async active-high reset.
`timescale 1ns/10ps
`default_nettype none
module itc_monitor
	import itc_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic o_wb_ack,
	input wire logic i_nmi_pin,
	input wire logic i_stack_overflow,
	input wire logic [3:0] i_cpu_level,
	input wire logic [1:0] i_cpu_trap_class,
	input wire logic o_vec_req,
	input wire logic [23:0] o_vec_addr,
	input wire logic [6:0] o_vec_trap_num,
	input wire logic [3:0] o_vec_level,
	input wire logic o_vec_is_trap,
	input wire logic i_vec_ack,
	input wire logic o_xfer_req,
	input wire logic [15:0] o_xfer_src,
	input wire logic i_xfer_ack,
	input wire logic [7:0] o_trap_flags
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);
	sequence vec_waiting;
		o_vec_req && !i_vec_ack;
	endsequence
	sequence nmi_offered;
		o_vec_req && o_vec_is_trap && o_vec_trap_num == TRAPNUM_NMI;
	endsequence
	chk_ack_next: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
		else $error("bus ack late");
	chk_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack) else $error("bus ack too long");
	chk_vec_stands: assert property (vec_waiting |=> o_vec_req) else $error("vector dropped");
	chk_vec_drop: assert property (o_vec_req && i_vec_ack |=> !o_vec_req)
		else $error("vector held after ack");
	chk_reset_offset: assert property (o_vec_req && o_vec_is_trap && o_vec_trap_num == TRAPNUM_RESET
		|-> o_vec_addr[15:0] == 16'h0000) else $error("reset offset wrong");
	chk_trap_level: assert property (o_vec_req && o_vec_is_trap |-> o_vec_level == i_cpu_level)
		else $error("trap level wrong");
	chk_nmi_fast: assert property ($fell(i_nmi_pin) && i_cpu_trap_class < CLASS_A
		|-> ##[1:8] nmi_offered) else $error("nmi not served");
	chk_trap_blocks: assert property (i_cpu_trap_class != CLASS_NONE && !o_vec_req
		|=> !o_vec_req || o_vec_is_trap) else $error("vector during trap");
	chk_xfer_blocked: assert property (i_cpu_trap_class != CLASS_NONE && !o_xfer_req
		|=> !o_xfer_req) else $error("transfer during trap");
	chk_xfer_stands: assert property (o_xfer_req && !i_xfer_ack
		|=> o_xfer_req && $stable(o_xfer_src)) else $error("transfer dropped");
	chk_flag_set: assert property (i_stack_overflow |=> o_trap_flags[FLAG_STACK_OVERFLOW_FLAG])
		else $error("trap flag not set");
	chk_flag_sticky: assert property (!(i_wb_cyc && i_wb_stb)
		|=> (o_trap_flags & $past(o_trap_flags)) == $past(o_trap_flags)) else $error("flag lost");
endmodule : itc_monitor
bind interrupt_and_trap_controller itc_monitor u_itc_monitor (.*);
`default_nettype wire

// ===== testbench/cpu_model.sv
// Behavioural CPU core answering vector and transfer requests.
// Assumes requests stand until acknowledged; the bench sets the answer delay.
`timescale 1ns/10ps
`default_nettype none
module cpu_model
(
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic [3:0] i_delay,
	input wire logic i_vec_req,
	input wire logic [39:0] i_vec_info,
	input wire logic i_xfer_req,
	input wire logic [32:0] i_xfer_info,
	output logic o_vec_ack,
	output logic o_xfer_ack
);
	logic [3:0] vwait_reg;
	logic [3:0] xwait_reg;
	logic [39:0] vec_seen;
	logic [32:0] xfer_seen;
	int n_vec;
	int n_xfer;
	// Fields are taken at the accepting edge, since a trap may replace them before
	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			o_vec_ack <= 1'b0;
			o_xfer_ack <= 1'b0;
			vwait_reg <= 4'h0;
			xwait_reg <= 4'h0;
			n_vec <= 0;
			n_xfer <= 0;
		end
		else
		begin
			if (o_vec_ack)
			begin
				vec_seen <= i_vec_info;
				n_vec <= n_vec + 1;
			end
			if (o_xfer_ack)
			begin
				xfer_seen <= i_xfer_info;
				n_xfer <= n_xfer + 1;
			end
			o_vec_ack <= i_vec_req && !o_vec_ack && vwait_reg == i_delay;
			o_xfer_ack <= i_xfer_req && !o_xfer_ack && xwait_reg == i_delay;
			vwait_reg <= (i_vec_req && !o_vec_ack && vwait_reg != i_delay) ? vwait_reg + 4'h1 : 4'h0;
			xwait_reg <= (i_xfer_req && !o_xfer_ack && xwait_reg != i_delay) ? xwait_reg + 4'h1 : 4'h0;
		end
	end
endmodule : cpu_model
`default_nettype wire

// ===== testbench/interrupt_and_trap_controller_tb_top.sv
// Directed bench for the interrupt and trap controller.
// Assumes the CPU model acknowledges every request; Wishbone tasks drive the registers.
`timescale 1ns/10ps
`default_nettype none
module interrupt_and_trap_controller_tb_top;
	import itc_pkg::*;
	logic i_clk = 1'b0, i_reset = 1'b1, i_wb_cyc = 1'b0, i_wb_stb = 1'b0, i_wb_we = 1'b0;
	logic [7:0] i_wb_adr = 8'h00, i_fast_ext_irq_input = 8'h00, i_periph_req = 8'h00, o_trap_flags;
	logic [31:0] i_wb_dat = 32'h0, o_wb_dat, q;
	logic o_wb_ack, o_vec_req, o_vec_is_trap, o_xfer_req, o_xfer_word, i_vec_ack, i_xfer_ack;
	logic i_nmi_pin = 1'b1, i_stack_overflow = 1'b0, i_soft_break = 1'b0, i_undef_opcode = 1'b0;
	logic i_reset_event = 1'b0, i_trap_instr = 1'b0;
	logic i_stack_underflow = 1'b0, i_pmem_access_error = 1'b0, i_protected_fault = 1'b0;
	logic i_illegal_operand = 1'b0;
	logic [6:0] i_trap_instr_num = 7'h00, o_vec_trap_num;
	logic [3:0] i_cpu_level = 4'h0, o_vec_level, dly = 4'h0;
	logic [1:0] i_cpu_trap_class = 2'b00;
	logic [23:0] o_vec_addr;
	logic [15:0] o_xfer_src, o_xfer_dst;
	int mismatches = 0, n_compared = 0, cycles = 0, nv = 0, nx = 0;
	interrupt_and_trap_controller u_interrupt_and_trap_controller (.i_wb_sel(4'hF), .*);
	cpu_model u_cpu_model (.i_clk(i_clk), .i_reset(i_reset), .i_delay(dly), .i_vec_req(o_vec_req),
		.i_vec_info({4'h0, o_vec_is_trap, o_vec_trap_num, o_vec_level, o_vec_addr}),
		.i_xfer_req(o_xfer_req), .i_xfer_info({o_xfer_word, o_xfer_dst, o_xfer_src}),
		.o_vec_ack(i_vec_ack), .o_xfer_ack(i_xfer_ack));
	always #5 i_clk = ~i_clk;
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
	endtask : tick
	task automatic chk(input logic [39:0] g, input logic [39:0] e, input string m);
		n_compared++;
		if (g !== e)
		begin
			mismatches++;
			$display("ERROR %0t %s got %h expected %h", $time, m, g, e);
		end
	endtask : chk
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		i_wb_cyc <= 1'b1;
		i_wb_stb <= 1'b1;
		i_wb_we <= we;
		i_wb_adr <= a;
		i_wb_dat <= d;
		do @(posedge i_clk); while (o_wb_ack !== 1'b1);
		q = o_wb_dat;
		i_wb_cyc <= 1'b0;
		i_wb_stb <= 1'b0;
		tick(1);
	endtask : wb
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk({8'h00, q}, {8'h00, e}, "register read");
	endtask : rd
	// A missing answer is caught by the cycle ceiling
	task automatic await(input bit x);
		while ((x ? u_cpu_model.n_xfer - nx : u_cpu_model.n_vec - nv) == 0)
			tick(1);
	endtask : await
	task automatic exp_vec(input logic [6:0] n, input logic [23:0] a, input logic [3:0] l);
		await(1'b0);
		chk(u_cpu_model.vec_seen, {4'h0, n[6:4] != 3'h4, n, l, a}, "vector");
		nv++;
	endtask : exp_vec
	task automatic exp_xfer(input logic [15:0] s, input logic [15:0] d, input logic w);
		await(1'b1);
		chk({7'h00, u_cpu_model.xfer_seen}, {7'h00, w, d, s}, "transfer");
		nx++;
	endtask : exp_xfer
	task automatic none_vec();
		tick(12);
		chk(40'(u_cpu_model.n_vec - nv), 40'h0, "unexpected vector");
	endtask : none_vec
	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : summarize
	always @(posedge i_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			mismatches++;
			summarize();
		end
	end
	initial
	begin
		tick(6);
		i_reset <= 1'b0;
		exp_vec(TRAPNUM_RESET, 24'h000000, 4'h0);
		rd(VEC_SEG_OFS, 32'h0);
		rd(CPU_CFG_OFS, 32'h0);
		rd(8'hFC, 32'h0);
		wb(1'b1, VEC_SEG_OFS, 32'h12);
		i_cpu_level <= 4'h3;
		wb(1'b1, 8'h34, 32'hC8);
		wb(1'b1, 8'h30, 32'hD4);
		exp_vec(7'h4C, 24'h120130, 4'h5);
		none_vec();
		rd(8'h30, 32'h54);
		wb(1'b1, CPU_CFG_OFS, 32'h1);
		wb(1'b1, 8'h30, 32'hD4);
		exp_vec(7'h4C, 24'h120260, 4'h5);
		wb(1'b1, CPU_CFG_OFS, 32'h0);
		i_cpu_level <= 4'h5;
		wb(1'b1, 8'h34, 32'hD4);
		none_vec();
		wb(1'b1, 8'h34, 32'hD8);
		exp_vec(7'h4D, 24'h120134, 4'h6);
		i_cpu_level <= 4'h0;
		wb(1'b1, EDGE_SEL_OFS, 32'h39);
		for (int n = 0; n < 3; n++)
		begin
			wb(1'b1, 8'(4 * n), 32'h44);
			i_fast_ext_irq_input[n] <= 1'b1;
			tick(12);
			if (n != 1) exp_vec(7'(7'h40 + n), 24'(24'h120100 + 4 * n), 4'h1);
			else none_vec();
			i_fast_ext_irq_input[n] <= 1'b0;
			tick(12);
			if (n != 0) exp_vec(7'(7'h40 + n), 24'(24'h120100 + 4 * n), 4'h1);
			else none_vec();
		end
		dly <= 4'h3;
		wb(1'b1, 8'hA0, 32'h1000);
		wb(1'b1, 8'hA4, 32'h2000);
		wb(1'b1, 8'hA8, 32'h702);
		wb(1'b1, 8'h24, 32'h550);
		for (int k = 0; k < 2; k++)
		begin
			i_periph_req[1] <= 1'b1;
			tick(1);
			i_periph_req[1] <= 1'b0;
			exp_xfer(16'(16'h1000 + 2 * k), 16'(16'h2000 + 2 * k), 1'b1);
		end
		exp_vec(7'h49, 24'h120124, 4'h4);
		rd(8'hA8, 32'h700);
		wb(1'b1, 8'hF0, 32'h3000);
		wb(1'b1, 8'hF4, 32'h4000);
		wb(1'b1, 8'hF8, 32'hA01);
		wb(1'b1, 8'h28, 32'hF50);
		i_periph_req[2] <= 1'b1;
		tick(1);
		i_periph_req[2] <= 1'b0;
		exp_xfer(16'h3000, 16'h4000, 1'b0);
		none_vec();
		rd(8'hF0, 32'h3001);
		rd(8'hF8, 32'hA01);
		dly <= 4'h0;
		{i_stack_overflow, i_stack_underflow, i_undef_opcode, i_pmem_access_error,
			i_protected_fault, i_illegal_operand} <= 6'h3F;
		tick(1);
		{i_stack_overflow, i_stack_underflow, i_undef_opcode, i_pmem_access_error,
			i_protected_fault, i_illegal_operand} <= 6'h00;
		exp_vec(TRAPNUM_STACK_OVERFLOW_FLAG, 24'h120010, 4'h0);
		exp_vec(TRAPNUM_STACK_UNDERFLOW_FLAG, 24'h120018, 4'h0);
		repeat (4) exp_vec(TRAPNUM_CLASS_B, 24'h120028, 4'h0);
		rd(TRAP_FLAG_OFS, 32'h6F);
		wb(1'b1, TRAP_FLAG_OFS, 32'h6F);
		rd(TRAP_FLAG_OFS, 32'h0);
		i_soft_break <= 1'b1;
		tick(1);
		i_soft_break <= 1'b0;
		exp_vec(TRAPNUM_BRK, 24'h120020, 4'h0);
		i_nmi_pin <= 1'b0;
		exp_vec(TRAPNUM_NMI, 24'h120008, 4'h0);
		i_nmi_pin <= 1'b1;
		i_reset_event <= 1'b1;
		tick(1);
		i_reset_event <= 1'b0;
		exp_vec(TRAPNUM_RESET, 24'h120000, 4'h0);
		i_cpu_level <= 4'h7;
		i_trap_instr_num <= 7'h7F;
		i_trap_instr <= 1'b1;
		tick(1);
		i_trap_instr <= 1'b0;
		exp_vec(7'h7F, 24'h1201FC, 4'h7);
		i_cpu_level <= 4'h0;
		i_cpu_trap_class <= CLASS_A;
		wb(1'b1, 8'h30, 32'hD4);
		none_vec();
		i_cpu_trap_class <= CLASS_NONE;
		exp_vec(7'h4C, 24'h120130, 4'h5);
		summarize();
	end
endmodule : interrupt_and_trap_controller_tb_top
`default_nettype wire
